/* File: hw/fps_map.vh */
`ifndef FPS_MAP_VH
`define FPS_MAP_VH
// ----------------------------------------
// Command bytes
// ----------------------------------------
`define FPS_CMD_READ 8'h00
`define FPS_CMD_ERASE_SETUP 8'h20
`define FPS_CMD_PROG_SETUP 8'h40
`define FPS_CMD_ERASE_VERIFY 8'hA0
`define FPS_CMD_PROG_VERIFY 8'hC0
`define FPS_CMD_RESET 8'hFF
// ----------------------------------------
// Data patterns
// ----------------------------------------
`define FPS_DATA_ERASED 8'hFF
`define FPS_DATA_ZERO 8'h00
// ----------------------------------------
// Timing, 50 MHz system clock
// ----------------------------------------
`define FPS_CLK_MHZ 50
`define FPS_PROG_PULSE_US 10
`define FPS_PROG_PULSE_CYC (`FPS_PROG_PULSE_US * `FPS_CLK_MHZ)
`define FPS_ERASE_PULSE_MS 10
`define FPS_ERASE_PULSE_CYC (`FPS_ERASE_PULSE_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_MAX_PROG_TRIES 25
// ----------------------------------------
// Bus cycle phase and supply settle lengths in clocks
// ----------------------------------------
`define FPS_BUS_SETUP_CYC 2
`define FPS_BUS_STROBE_CYC 4
`define FPS_BUS_HOLD_CYC 2
`define FPS_VPP_SETTLE_CYC 100
// ----------------------------------------
// Failure codes
// ----------------------------------------
`define FPS_ERR_NONE 2'h0
`define FPS_ERR_PROG 2'h1
`define FPS_ERR_ERASE 2'h2
`endif

/* File: hw/fps_bus_cycle.v */
`include "fps_map.vh"
// One write or read cycle on the asynchronous memory bus
module fps_bus_cycle #(
    parameter AW = 17
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Request from sequencer
    input wire req,
    input wire wr,
    input wire [AW-1:0] addr,
    input wire [7:0] wdata,
    output wire done,
    output reg [7:0] rdata_q,
    // Memory pins
    output reg [AW-1:0] mem_addr_q,
    output reg [7:0] mem_dq_out_q,
    output reg mem_dq_oe_q,
    input wire [7:0] mem_dq_in,
    output reg mem_ce_n_q,
    output reg mem_we_n_q,
    output reg mem_oe_n_q
);
    // ----------------------------------------
    // Phase machine
    // ----------------------------------------
    localparam P_IDLE = 2'd0;
    localparam P_SETUP = 2'd1;
    localparam P_STROBE = 2'd2;
    localparam P_HOLD = 2'd3;
    localparam integer SETUP_M1 = `FPS_BUS_SETUP_CYC - 1; // Set-up clocks less one
    localparam integer STROBE_M1 = `FPS_BUS_STROBE_CYC - 1; // Strobe clocks less one
    localparam integer HOLD_M1 = `FPS_BUS_HOLD_CYC - 1; // Hold clocks less one
    reg [1:0] ph_q; // Current phase
    reg [3:0] cnt_q; // Phase cycle counter
    reg wr_q; // Latched direction
    reg [7:0] dq_s1_q; // Read data sync stage 1
    reg [7:0] dq_s2_q; // Read data sync stage 2
    assign done = (ph_q == P_HOLD) && (cnt_q == 4'd0);
    // Read data synchroniser
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end else begin
            dq_s1_q <= mem_dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end
    // Strobe sequencing; writes need select and write strobe low together
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= P_IDLE;
            cnt_q <= 4'd0;
            wr_q <= 1'b0;
            rdata_q <= 8'h00;
            mem_addr_q <= {AW{1'b0}};
            mem_dq_out_q <= 8'h00;
            mem_dq_oe_q <= 1'b0;
            mem_ce_n_q <= 1'b1;
            mem_we_n_q <= 1'b1;
            mem_oe_n_q <= 1'b1;
        end else begin
            case (ph_q)
                P_IDLE: begin
                    if (req) begin
                        // Address and data settle before strobes
                        mem_addr_q <= addr;
                        mem_dq_out_q <= wdata;
                        mem_dq_oe_q <= wr;
                        wr_q <= wr;
                        mem_ce_n_q <= 1'b0;
                        cnt_q <= SETUP_M1[3:0];
                        ph_q <= P_SETUP;
                    end
                end
                P_SETUP: begin
                    if (cnt_q == 4'd0) begin
                        // Falling strobe: device latches address here
                        mem_we_n_q <= ~wr_q;
                        mem_oe_n_q <= wr_q;
                        cnt_q <= STROBE_M1[3:0];
                        ph_q <= P_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 4'd1;
                    end
                end
                P_STROBE: begin
                    if (cnt_q == 4'd0) begin
                        // Rising strobe: device latches data here
                        if (!wr_q) begin
                            rdata_q <= dq_s2_q;
                        end
                        mem_we_n_q <= 1'b1;
                        mem_oe_n_q <= 1'b1;
                        cnt_q <= HOLD_M1[3:0];
                        ph_q <= P_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 4'd1;
                    end
                end
                P_HOLD: begin
                    if (cnt_q == 4'd0) begin
                        // Release bus, chip deselected inhibits writes
                        mem_ce_n_q <= 1'b1;
                        mem_dq_oe_q <= 1'b0;
                        ph_q <= P_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'd1;
                    end
                end
                default: begin
                    ph_q <= P_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: hw/fps_sequencer.v */
`include "fps_map.vh"
module fps_sequencer #(
    parameter AW = 17,
    parameter ERASE_PULSE_CYC = `FPS_ERASE_PULSE_CYC,
    parameter MAX_ERASE_PULSES = 1000
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Operation requests
    input wire op_prog,
    input wire op_erase,
    input wire op_abort,
    input wire [AW-1:0] op_addr,
    input wire [7:0] op_data,
    output wire op_ready,
    output reg op_done_q,
    output reg [1:0] op_err_q,
    output reg [AW-1:0] op_fail_addr_q,
    output reg erase_skipped_q,
    // Memory pins
    output wire [AW-1:0] mem_addr,
    output wire [7:0] mem_dq_out,
    output wire mem_dq_oe,
    input wire [7:0] mem_dq_in,
    output wire mem_ce_n,
    output wire mem_we_n,
    output wire mem_oe_n,
    output reg mem_vpp_en_q
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam S_IDLE = 5'd0;
    localparam S_VPP_UP = 5'd1;
    localparam S_P_SETUP = 5'd2;
    localparam S_P_WRITE = 5'd3;
    localparam S_P_PULSE = 5'd4;
    localparam S_P_VCMD = 5'd5;
    localparam S_P_VREAD = 5'd6;
    localparam S_P_CHECK = 5'd7;
    localparam S_E_SCAN = 5'd8;
    localparam S_E_SCHK = 5'd9;
    localparam S_E_SETUP = 5'd10;
    localparam S_E_GO = 5'd11;
    localparam S_E_PULSE = 5'd12;
    localparam S_E_VCMD = 5'd13;
    localparam S_E_VREAD = 5'd14;
    localparam S_E_CHECK = 5'd15;
    localparam S_AB_1 = 5'd16;
    localparam S_AB_2 = 5'd17;
    localparam S_RD_CMD = 5'd18;
    localparam S_FINISH = 5'd19;
    localparam [AW-1:0] LAST_ADDR = {AW{1'b1}};
    localparam [5:0] MAX_TRIES = `FPS_MAX_PROG_TRIES;
    localparam [25:0] PPULSE = `FPS_PROG_PULSE_CYC;
    localparam [25:0] EPULSE = ERASE_PULSE_CYC;
    localparam [25:0] VSETTLE = `FPS_VPP_SETTLE_CYC;
    localparam [31:0] MAX_EPULSES = MAX_ERASE_PULSES; // Erase pulse budget
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [4:0] st_q; // Sequencer state
    reg [4:0] ret_q; // State after supply settles
    reg issued_q; // Bus cycle in flight
    reg [25:0] tmr_q; // Pulse timer
    reg [5:0] tries_q; // Program attempts this byte
    reg [9:0] epulses_q; // Erase pulses spent
    reg [AW-1:0] addr_q; // Working address
    reg [7:0] data_q; // Target byte
    reg preprog_q; // Pre-programming pass of erase
    reg aborting_q; // Abort requested mid sequence
    reg [AW-1:0] resume_q; // Last verified erase address
    // Bus request
    reg bus_req; // Start a bus cycle
    reg bus_wr; // Write direction
    reg [AW-1:0] bus_addr; // Cycle address
    reg [7:0] bus_wdata; // Cycle data
    wire bus_done; // Cycle complete
    wire [7:0] bus_rdata; // Captured read data
    assign op_ready = (st_q == S_IDLE);
    // ----------------------------------------
    // Bus cycle engine
    // ----------------------------------------
    fps_bus_cycle #(
        .AW(AW)
    ) u_bus (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .req(bus_req),
        .wr(bus_wr),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .done(bus_done),
        .rdata_q(bus_rdata),
        .mem_addr_q(mem_addr),
        .mem_dq_out_q(mem_dq_out),
        .mem_dq_oe_q(mem_dq_oe),
        .mem_dq_in(mem_dq_in),
        .mem_ce_n_q(mem_ce_n),
        .mem_we_n_q(mem_we_n),
        .mem_oe_n_q(mem_oe_n)
    );
    // ----------------------------------------
    // Bus request per state
    // ----------------------------------------
    always @* begin
        bus_req = 1'b0;
        bus_wr = 1'b1;
        bus_addr = {AW{1'b0}};
        bus_wdata = 8'h00;
        case (st_q)
            S_P_SETUP: begin
                bus_wdata = `FPS_CMD_PROG_SETUP;
            end
            S_P_WRITE: begin
                // Address and data of the byte to program
                bus_addr = addr_q;
                bus_wdata = data_q;
            end
            S_P_VCMD: begin
                bus_wdata = `FPS_CMD_PROG_VERIFY;
            end
            S_P_VREAD, S_E_VREAD, S_E_SCAN: begin
                bus_wr = 1'b0;
                bus_addr = addr_q;
            end
            S_E_SETUP, S_E_GO: begin
                bus_wdata = `FPS_CMD_ERASE_SETUP;
            end
            S_E_VCMD: begin
                bus_addr = addr_q;
                bus_wdata = `FPS_CMD_ERASE_VERIFY;
            end
            S_AB_1, S_AB_2: begin
                bus_wdata = `FPS_CMD_RESET;
            end
            S_RD_CMD: begin
                bus_wdata = `FPS_CMD_READ;
            end
            default: begin
                bus_wdata = 8'h00;
            end
        endcase
        case (st_q)
            S_P_SETUP, S_P_WRITE, S_P_VCMD, S_P_VREAD, S_E_VREAD, S_E_SCAN,
            S_E_SETUP, S_E_GO, S_E_VCMD, S_AB_1, S_AB_2, S_RD_CMD: begin
                bus_req = !issued_q;
            end
            default: begin
                bus_req = 1'b0;
            end
        endcase
    end
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            ret_q <= S_IDLE;
            issued_q <= 1'b0;
            tmr_q <= 26'd0;
            tries_q <= 6'd0;
            epulses_q <= 10'd0;
            addr_q <= {AW{1'b0}};
            data_q <= 8'h00;
            preprog_q <= 1'b0;
            aborting_q <= 1'b0;
            resume_q <= {AW{1'b0}};
            op_done_q <= 1'b0;
            op_err_q <= `FPS_ERR_NONE;
            op_fail_addr_q <= {AW{1'b0}};
            erase_skipped_q <= 1'b0;
            mem_vpp_en_q <= 1'b0;
        end else begin
            op_done_q <= 1'b0;
            if (bus_req) begin
                issued_q <= 1'b1;
            end else if (bus_done) begin
                issued_q <= 1'b0;
            end
            // Abort may land while a set-up is pending
            if (op_abort && st_q != S_IDLE) begin
                aborting_q <= 1'b1;
            end
            case (st_q)
                S_IDLE: begin
                    aborting_q <= 1'b0;
                    if (op_prog) begin
                        addr_q <= op_addr;
                        data_q <= op_data;
                        preprog_q <= 1'b0;
                        op_err_q <= `FPS_ERR_NONE;
                        ret_q <= S_P_SETUP;
                        mem_vpp_en_q <= 1'b1;
                        tmr_q <= VSETTLE;
                        st_q <= S_VPP_UP;
                    end else if (op_erase) begin
                        addr_q <= {AW{1'b0}};
                        op_err_q <= `FPS_ERR_NONE;
                        erase_skipped_q <= 1'b0;
                        st_q <= S_E_SCAN;
                    end
                end
                S_VPP_UP: begin
                    if (tmr_q == 26'd0) begin
                        tries_q <= 6'd0;
                        st_q <= ret_q;
                    end else begin
                        tmr_q <= tmr_q - 26'd1;
                    end
                end
                S_P_SETUP: begin
                    if (issued_q && bus_done) begin
                        // Abort only between set-up and execute
                        st_q <= aborting_q ? S_AB_1 : S_P_WRITE;
                    end
                end
                S_P_WRITE: begin
                    if (issued_q && bus_done) begin
                        tries_q <= tries_q + 6'd1;
                        tmr_q <= PPULSE;
                        st_q <= S_P_PULSE;
                    end
                end
                S_P_PULSE: begin
                    // Pulse timed from write to verify command
                    if (tmr_q == 26'd0) begin
                        st_q <= S_P_VCMD;
                    end else begin
                        tmr_q <= tmr_q - 26'd1;
                    end
                end
                S_P_VCMD: begin
                    if (issued_q && bus_done) begin
                        st_q <= S_P_VREAD;
                    end
                end
                S_P_VREAD: begin
                    if (issued_q && bus_done) begin
                        st_q <= S_P_CHECK;
                    end
                end
                S_P_CHECK: begin
                    if (bus_rdata == data_q) begin
                        if (preprog_q && addr_q != LAST_ADDR) begin
                            // Next byte of the zero pass
                            addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                            tries_q <= 6'd0;
                            st_q <= S_P_SETUP;
                        end else if (preprog_q) begin
                            addr_q <= {AW{1'b0}};
                            resume_q <= {AW{1'b0}};
                            epulses_q <= 10'd0;
                            st_q <= S_E_SETUP;
                        end else begin
                            st_q <= S_RD_CMD;
                        end
                    end else if (tries_q >= MAX_TRIES) begin
                        // Out of attempts: report and stop
                        op_err_q <= `FPS_ERR_PROG;
                        op_fail_addr_q <= addr_q;
                        st_q <= S_RD_CMD;
                    end else begin
                        st_q <= S_P_SETUP;
                    end
                end
                S_E_SCAN: begin
                    if (issued_q && bus_done) begin
                        st_q <= S_E_SCHK;
                    end
                end
                S_E_SCHK: begin
                    if (bus_rdata != `FPS_DATA_ERASED) begin
                        // Not blank: pre-program whole array to zero
                        addr_q <= {AW{1'b0}};
                        data_q <= `FPS_DATA_ZERO;
                        preprog_q <= 1'b1;
                        ret_q <= S_P_SETUP;
                        mem_vpp_en_q <= 1'b1;
                        tmr_q <= VSETTLE;
                        st_q <= S_VPP_UP;
                    end else if (addr_q == LAST_ADDR) begin
                        erase_skipped_q <= 1'b1;
                        op_done_q <= 1'b1;
                        st_q <= S_IDLE;
                    end else begin
                        addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                        st_q <= S_E_SCAN;
                    end
                end
                S_E_SETUP: begin
                    if (issued_q && bus_done) begin
                        st_q <= aborting_q ? S_AB_1 : S_E_GO;
                    end
                end
                S_E_GO: begin
                    if (issued_q && bus_done) begin
                        epulses_q <= epulses_q + 10'd1;
                        tmr_q <= EPULSE;
                        st_q <= S_E_PULSE;
                    end
                end
                S_E_PULSE: begin
                    if (tmr_q == 26'd0) begin
                        addr_q <= resume_q;
                        st_q <= S_E_VCMD;
                    end else begin
                        tmr_q <= tmr_q - 26'd1;
                    end
                end
                S_E_VCMD: begin
                    if (issued_q && bus_done) begin
                        st_q <= S_E_VREAD;
                    end
                end
                S_E_VREAD: begin
                    if (issued_q && bus_done) begin
                        st_q <= S_E_CHECK;
                    end
                end
                S_E_CHECK: begin
                    if (bus_rdata == `FPS_DATA_ERASED) begin
                        resume_q <= addr_q;
                        if (addr_q == LAST_ADDR) begin
                            st_q <= S_RD_CMD;
                        end else begin
                            addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                            st_q <= S_E_VCMD;
                        end
                    end else if ({22'd0, epulses_q} >= MAX_EPULSES) begin
                        op_err_q <= `FPS_ERR_ERASE;
                        op_fail_addr_q <= addr_q;
                        st_q <= S_RD_CMD;
                    end else begin
                        st_q <= S_E_SETUP;
                    end
                end
                S_AB_1: begin
                    if (issued_q && bus_done) begin
                        st_q <= S_AB_2;
                    end
                end
                S_AB_2: begin
                    if (issued_q && bus_done) begin
                        st_q <= S_RD_CMD;
                    end
                end
                S_RD_CMD: begin
                    if (issued_q && bus_done) begin
                        st_q <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    mem_vpp_en_q <= 1'b0;
                    op_done_q <= 1'b1;
                    st_q <= S_IDLE;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: tb/fps_flash_model.sv */
// ----------------------------------------
// Behavioural byte-wide flash device
// ----------------------------------------
module fps_flash_model #(
    parameter int AW = 4
) (
    // Bus pins
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] dq_w,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic vpp,
    output logic [7:0] dq_r,
    // Fault control: programming never takes
    input wire logic stuck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:(1<<AW)-1]; // Array, never blank at start
    logic [7:0] cmd_q = 8'h00; // Read mode at power-up
    logic [AW-1:0] lat_q = '0; // Latched address
    int pulses = 0; // Program pulses seen
    realtime t_q = 0;
    realtime pulse_ns = 0; // Length of last program pulse
    initial begin
        dq_r = 8'h00;
        for (int i = 0; i < (1 << AW); i++) begin
            mem[i] = 8'h5A ^ 8'(i);
        end
    end
    // Address on falling strobe, not for program verify
    always @(negedge we_n) begin
        if (!ce_n && (cmd_q == 8'h40 || dq_w != 8'hC0)) begin
            lat_q = addr;
        end
    end
    // Commands on rising strobe, only with select low
    always @(posedge we_n) begin
        if (!ce_n) begin
            if ((cmd_q == 8'h40 || cmd_q == 8'h20) && dq_w == 8'hFF) begin
                cmd_q = 8'hFE; // First reset write
            end else if (cmd_q == 8'hFE && dq_w == 8'hFF) begin
                cmd_q = 8'hFF; // Aborted, array untouched
            end else if (cmd_q == 8'h40) begin
                if (!stuck && vpp) mem[lat_q] = mem[lat_q] & dq_w;
                pulses++;
                t_q = $realtime;
                cmd_q = 8'h01;
            end else if (cmd_q == 8'h20 && dq_w == 8'h20) begin
                if (vpp) foreach (mem[i]) mem[i] = 8'hFF;
                cmd_q = 8'h02;
            end else begin
                if (cmd_q == 8'h01) pulse_ns = $realtime - t_q;
                cmd_q = dq_w;
            end
        end
    end
    // Margin reads at latched address; released bus toggles
    always @(oe_n, ce_n, addr) begin
        if (!oe_n && !ce_n) begin
            dq_r = mem[(cmd_q == 8'hC0 || cmd_q == 8'hA0) ? lat_q : addr];
        end else begin
            dq_r = ~dq_r;
        end
    end
endmodule

/* File: tb/fps_sequencer_properties.sv */
// ----------------------------------------
// Pin protocol checks for the sequencer
// ----------------------------------------
module fps_sequencer_properties #(
    parameter AW = 17
) (
    input wire clk_sys,
    input wire rst_n,
    input wire op_prog,
    input wire op_ready,
    input wire op_done_q,
    input wire [AW-1:0] mem_addr,
    input wire [7:0] mem_dq_out,
    input wire mem_dq_oe,
    input wire mem_ce_n,
    input wire mem_we_n,
    input wire mem_oe_n,
    input wire mem_vpp_en_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence we_low4;
        !mem_we_n [*4];
    endsequence
    sequence we_up;
        ##1 mem_we_n;
    endsequence
    strobe_pair_a: assert property (!mem_we_n |-> !mem_ce_n && mem_oe_n)
        else $error("write strobe without select");
    we_width_a: assert property ($fell(mem_we_n) |-> we_low4 ##0 we_up)
        else $error("write strobe width wrong");
    addr_hold_a: assert property (!mem_we_n && !$past(mem_we_n) |->
        $stable(mem_addr) && $stable(mem_dq_out))
        else $error("address or data moved in strobe");
    wr_drive_a: assert property (!mem_we_n |-> mem_dq_oe)
        else $error("write without data drive");
    rd_release_a: assert property (!mem_oe_n |-> !mem_dq_oe)
        else $error("read while driving data");
    vpp_write_a: assert property ($fell(mem_we_n) && (mem_dq_out == 8'h40 ||
        mem_dq_out == 8'hC0 || mem_dq_out == 8'h20) |-> mem_vpp_en_q)
        else $error("command without high supply");
    ce_lead_a: assert property ($fell(mem_ce_n) |-> (mem_we_n && mem_oe_n) [*2])
        else $error("strobe too soon after select");
    done_pulse_a: assert property (op_done_q |=> !op_done_q)
        else $error("done longer than one cycle");
    take_busy_a: assert property (op_ready && op_prog |=> !op_ready)
        else $error("request not taken");
endmodule
bind fps_sequencer fps_sequencer_properties #(.AW(AW)) u_props (.clk_sys, .rst_n,
    .op_prog, .op_ready, .op_done_q, .mem_addr, .mem_dq_out, .mem_dq_oe, .mem_ce_n,
    .mem_we_n, .mem_oe_n, .mem_vpp_en_q);

/* File: tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 4;
    logic clk_sys = 0, rst_n = 0, op_prog = 0, op_erase = 0, op_abort = 0, stuck = 0;
    logic [AW-1:0] op_addr = '0;
    logic [7:0] op_data = 8'h00;
    logic [7:0] dq_in;
    wire op_ready, op_done_q, erase_skipped_q, dq_oe, ce_n, we_n, oe_n, vpp;
    wire [1:0] op_err_q;
    wire [AW-1:0] fail_addr, mem_addr;
    wire [7:0] dq_out;
    int err_total = 0, tests_run = 0, cyc = 0;
    fps_sequencer #(.AW(AW), .ERASE_PULSE_CYC(50)) uut (.clk_sys(clk_sys),
        .rst_n(rst_n), .op_prog(op_prog), .op_erase(op_erase), .op_abort(op_abort),
        .op_addr(op_addr), .op_data(op_data), .op_ready(op_ready), .op_done_q(op_done_q),
        .op_err_q(op_err_q), .op_fail_addr_q(fail_addr), .erase_skipped_q(erase_skipped_q),
        .mem_addr(mem_addr), .mem_dq_out(dq_out), .mem_dq_oe(dq_oe), .mem_dq_in(dq_in),
        .mem_ce_n(ce_n), .mem_we_n(we_n), .mem_oe_n(oe_n), .mem_vpp_en_q(vpp));
    fps_flash_model #(.AW(AW)) flash (.addr(mem_addr), .dq_w(dq_out), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .vpp(vpp), .dq_r(dq_in), .stuck(stuck));
    // Clock, 20 ns period
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 95000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One operation, waits for the done pulse
    task automatic run(input logic p, input logic e, input logic a,
                       input logic [AW-1:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        op_prog = p;
        op_erase = e;
        op_abort = a;
        op_addr = ad;
        op_data = d;
        @(negedge clk_sys);
        op_prog = 0;
        op_erase = 0;
        while (op_done_q !== 1'b1 && n < 60000) begin
            @(negedge clk_sys);
            n++;
        end
        op_abort = 0;
        if (n >= 60000) begin
            err_total++;
            $display("[ERR] %0t operation never finished", $time);
        end
    endtask
    task automatic t_erase();
        run(0, 1, 0, '0, 8'h00);
        chk(op_err_q, 2'h0);
        chk(erase_skipped_q, 1'b0);
        chk(flash.pulses, 1 << AW);
        for (int i = 0; i < (1 << AW); i++) chk(flash.mem[i], 8'hFF);
        run(0, 1, 0, '0, 8'h00);
        chk(erase_skipped_q, 1'b1);
        chk(flash.pulses, 1 << AW);
        $display("t_erase done");
    endtask
    task automatic t_abort();
        run(1, 0, 1, 4'h7, 8'h00);
        chk(flash.mem[7], 8'hFF);
        chk(flash.pulses, 1 << AW);
        chk(flash.cmd_q, 8'h00);
        $display("t_abort done");
    endtask
    task automatic t_prog();
        run(1, 0, 0, 4'h5, 8'h5A);
        chk(op_err_q, 2'h0);
        chk(flash.mem[5], 8'h5A);
        chk(flash.pulses, (1 << AW) + 1);
        chk(flash.pulse_ns >= 10000.0 && flash.pulse_ns < 11000.0, 1'b1);
        $display("t_prog done");
    endtask
    task automatic t_fail();
        int b;
        b = flash.pulses;
        stuck = 1;
        run(1, 0, 0, 4'h6, 8'h00);
        stuck = 0;
        chk(op_err_q, 2'h1);
        chk(fail_addr, 4'h6);
        chk(flash.pulses - b, 25);
        $display("t_fail done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        chk(op_ready, 1'b1);
        chk(we_n, 1'b1);
        rst_n = 1;
        t_erase();
        t_abort();
        t_prog();
        t_fail();
        summarize();
    end
endmodule
